// ---- his_pkg.sv ----
// package: register map, field positions and carriers for the hub interrupt/status block
package his_pkg;
  localparam int unsigned ADDR_W = 12;
  // printed offsets are not multiples of four: kept as indices, byte address is index * 4
  localparam logic [7:0] IDX_FORWARDING_SYNC_STATUS = 8'h22;
  localparam logic [7:0] IDX_IRQ_CTL = 8'h23;
  localparam logic [7:0] IDX_IRQ_SUM = 8'h24;
  localparam logic [7:0] IDX_STAMP_CFG = 8'h25;
  localparam logic [7:0] IDX_FWD_CTL = 8'h30;
  localparam logic [7:0] IDX_EVT_STS = 8'h31;
  localparam logic [7:0] IDX_EVT_MASK = 8'h32;
  localparam logic [7:0] RST_IRQ_CTL = 8'h00;
  localparam logic [7:0] RST_STAMP_CFG = 8'h00;
  localparam logic [7:0] RST_FWD_CTL = 8'h00;
  localparam logic [7:0] RST_EVT_MASK = 8'h00;
  localparam int unsigned BIT_GLOBAL_EN = 7;
  localparam int unsigned BIT_SUMMARY = 7;
  localparam int unsigned BIT_TX0 = 4;
  localparam int unsigned BIT_SYNC_FAIL = 2;
  localparam int unsigned BIT_SYNCED = 0;
  localparam int unsigned BIT_EDGE = 6;
  localparam int unsigned LSB_RES = 4;
  localparam int unsigned BIT_EARLY = 3;
  localparam int unsigned BIT_FREE = 1;
  localparam int unsigned BIT_TRIG = 0;
  localparam logic [1:0] SYNC_FWD_OFF = 2'h0;
  // event status bits (own register)
  localparam int unsigned EVT_FAIL = 0;
  localparam int unsigned EVT_SYNC = 1;
  localparam int unsigned EVT_SUM = 2;
  localparam int unsigned EVT_W = 3;
  // resolution per count in ns
  localparam int unsigned RES0_NS = 40;
  localparam int unsigned RES1_NS = 80;
  localparam int unsigned RES2_NS = 160;
  localparam int unsigned RES3_NS = 1000;
  localparam int unsigned CLK_NS = 25;

  typedef enum logic [1:0] {
    HIS_IDLE,
    HIS_ACCESS
  } his_phase_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } his_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } his_apb_rsp_t;

  typedef struct packed {
    logic edge_falling;
    logic [1:0] resolution;
    logic early_ready;
    logic free_run;
    logic frame_start;
  } his_stamp_t;

  // source-register read strobes from the rest of the device
  typedef struct packed {
    logic tx0_cause_read;
    logic [3:0] port_a_read;
    logic [3:0] port_b_read;
    logic [3:0] port_csi_read;
  } his_clr_t;

  typedef struct packed {
    his_phase_t phase;
    logic [7:0] irq_control;
    logic [7:0] stamp_config;
    logic [1:0] sync_fwd;
    logic frame_done;
    logic sync_fail;
    logic synced;
    logic [4:0] src_flag;
    logic summary;
    logic [EVT_W-1:0] evt_sts;
    logic [EVT_W-1:0] evt_mask;
    logic irq;
    logic ext_irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    his_stamp_t stamp;
    logic [7:0] stamp_ns_cycles;
  } his_state_t;
endpackage

// ---- his_top.sv ----
// hub interrupt aggregation, forwarding sync status and timestamp config over apb
// Behaviour
// - sync failure flag sets on lost sync only after one synced frame forwarded
// - reading forwarding status clears failure flag; one means failure
// - synchronized bit follows engine, forced zero when synchronized forwarding is off
// - irq control bit 7 is global enable gating the host interrupt line
// - enables: bit 4 transmitter, bits 3..0 receive ports 3..0
// - summary bit 7 set when any enabled source flag is set, ignores global enable
// - transmitter flag sets on its interrupt, clears only on its cause register read
// - port flag clears on read of its two condition registers or csi register
// - frame sync edge select zero rising, one falling
// - two-bit resolution: 40, 80, 160 ns or 1.0 us per count
// - early ready bit makes ready as soon as all port stamps available
// - free run select zero frame sync mode, one free run mode
// - trigger select zero line start, one frame start
// - two-bit sync forwarding select, 00 disables, others select sync modes
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
module his_top #(
  parameter int unsigned NUM_PORTS = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire his_pkg::his_apb_req_t i_apb,
  output his_pkg::his_apb_rsp_t o_apb,
  input wire logic i_frame_forwarded,
  input wire logic i_sync_lost,
  input wire logic i_engine_synced,
  input wire logic i_tx0_irq,
  input wire logic [NUM_PORTS-1:0] i_port_irq,
  input wire his_pkg::his_clr_t i_clr,
  output logic o_host_irq,
  output logic o_evt_irq,
  output logic [1:0] o_sync_forwarding_select,
  output his_pkg::his_stamp_t o_stamp,
  output logic [7:0] o_stamp_count_ns
);
  import his_pkg::*;

  initial begin
    if (NUM_PORTS != 4) begin
      $error("his_top supports exactly four receive ports");
    end
  end

  his_state_t st;
  his_state_t next_st;
  logic [7:0] idx;
  logic wr_en;
  logic rd_en;
  logic [4:0] enables;
  logic [4:0] clr_src;
  logic [7:0] forwarding_sync_status_val;
  logic [7:0] sum_val;
  logic [EVT_W-1:0] evt_set;

  default clocking his_cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  always_comb begin
    next_st = st;
    idx = i_apb.paddr[ADDR_W-1:2] > 10'h0ff ? 8'hff : i_apb.paddr[9:2];
    wr_en = 1'b0;
    rd_en = 1'b0;
    enables = st.irq_control[4:0];
    forwarding_sync_status_val = 8'h00;
    forwarding_sync_status_val[BIT_SYNC_FAIL] = st.sync_fail;
    forwarding_sync_status_val[BIT_SYNCED] = st.synced;
    sum_val = {st.summary, 2'h0, st.src_flag};
    clr_src[BIT_TX0] = i_clr.tx0_cause_read;
    clr_src[3:0] = i_clr.port_a_read | i_clr.port_b_read | i_clr.port_csi_read;
    evt_set = '0;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    // apb: one wait state, answer two cycles after setup
    case (st.phase)
      HIS_IDLE: begin
        if (i_apb.psel && !i_apb.penable) begin
          next_st.phase = HIS_ACCESS;
        end
      end
      HIS_ACCESS: begin
        if (i_apb.psel && i_apb.penable && !st.pready) begin
          next_st.pready = 1'b1;
          wr_en = i_apb.pwrite;
          rd_en = !i_apb.pwrite;
          next_st.prdata = 32'h0000_0000;
          case (idx)
            IDX_FORWARDING_SYNC_STATUS: next_st.prdata[7:0] = forwarding_sync_status_val;
            IDX_IRQ_CTL: next_st.prdata[7:0] = st.irq_control;
            IDX_IRQ_SUM: next_st.prdata[7:0] = sum_val;
            IDX_STAMP_CFG: next_st.prdata[7:0] = st.stamp_config;
            IDX_FWD_CTL: next_st.prdata[7:0] = {6'h00, st.sync_fwd};
            IDX_EVT_STS: next_st.prdata[7:0] = {5'h00, st.evt_sts};
            IDX_EVT_MASK: next_st.prdata[7:0] = {5'h00, st.evt_mask};
            default: next_st.pslverr = 1'b1;
          endcase
        end
        if (st.pready) begin
          next_st.phase = HIS_IDLE;
        end
      end
      default: next_st.phase = HIS_IDLE;
    endcase
    // register writes, reserved bits held at zero
    if (wr_en && !next_st.pslverr) begin
      case (idx)
        IDX_IRQ_CTL: next_st.irq_control = i_apb.pwdata[7:0] & 8'h9f;
        IDX_STAMP_CFG: next_st.stamp_config = i_apb.pwdata[7:0] & 8'h7b;
        IDX_FWD_CTL: next_st.sync_fwd = i_apb.pwdata[1:0];
        IDX_EVT_MASK: next_st.evt_mask = i_apb.pwdata[EVT_W-1:0];
        default: next_st.sync_fwd = next_st.sync_fwd;
      endcase
    end
    // forwarding sync status
    if (next_st.sync_fwd == SYNC_FWD_OFF) begin
      next_st.frame_done = 1'b0;
      next_st.synced = 1'b0;
    end else begin
      next_st.synced = i_engine_synced;
      if (i_frame_forwarded) begin
        next_st.frame_done = 1'b1;
      end
    end
    // clear on read, a set in the same cycle wins
    if (rd_en && idx == IDX_FORWARDING_SYNC_STATUS) begin
      next_st.sync_fail = 1'b0;
    end
    if (st.sync_fwd != SYNC_FWD_OFF && st.frame_done && i_sync_lost) begin
      next_st.sync_fail = 1'b1;
      evt_set[EVT_FAIL] = !st.sync_fail;
    end
    // source flags: sticky, cleared only by their source register reads
    next_st.src_flag = (st.src_flag & ~clr_src) | {i_tx0_irq, i_port_irq};
    next_st.summary = |(next_st.src_flag & enables);
    next_st.ext_irq = next_st.irq_control[BIT_GLOBAL_EN] && next_st.summary;
    evt_set[EVT_SYNC] = next_st.synced && !st.synced;
    evt_set[EVT_SUM] = next_st.summary && !st.summary;
    if (rd_en && idx == IDX_EVT_STS) begin
      next_st.evt_sts = '0;
    end
    next_st.evt_sts = next_st.evt_sts | evt_set;
    next_st.irq = |(next_st.evt_sts & next_st.evt_mask);
    // timestamp configuration decode
    next_st.stamp.edge_falling = next_st.stamp_config[BIT_EDGE];
    next_st.stamp.resolution = next_st.stamp_config[LSB_RES +: 2];
    next_st.stamp.early_ready = next_st.stamp_config[BIT_EARLY];
    next_st.stamp.free_run = next_st.stamp_config[BIT_FREE];
    next_st.stamp.frame_start = next_st.stamp_config[BIT_TRIG];
    case (next_st.stamp.resolution)
      2'h0: next_st.stamp_ns_cycles = 8'(RES0_NS / CLK_NS);
      2'h1: next_st.stamp_ns_cycles = 8'(RES1_NS / CLK_NS);
      2'h2: next_st.stamp_ns_cycles = 8'(RES2_NS / CLK_NS);
      default: next_st.stamp_ns_cycles = 8'(RES3_NS / CLK_NS);
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st <= '0;
      st.phase <= HIS_IDLE;
      st.irq_control <= RST_IRQ_CTL;
      st.stamp_config <= RST_STAMP_CFG;
      st.sync_fwd <= RST_FWD_CTL[1:0];
      st.evt_mask <= RST_EVT_MASK[EVT_W-1:0];
      st.stamp_ns_cycles <= 8'(RES0_NS / CLK_NS);
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    o_apb.prdata = st.prdata;
    o_apb.pready = st.pready;
    o_apb.pslverr = st.pslverr;
    o_host_irq = st.ext_irq;
    o_evt_irq = st.irq;
    o_sync_forwarding_select = st.sync_fwd;
    o_stamp = st.stamp;
    o_stamp_count_ns = st.stamp_ns_cycles;
  end

  sequence s_fwd_armed;
    st.sync_fwd != SYNC_FWD_OFF && st.frame_done;
  endsequence

  sequence s_lost;
    i_sync_lost;
  endsequence

  a_fail_needs_frame: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(st.sync_fail) |-> $past(st.frame_done) && $past(st.sync_fwd) != SYNC_FWD_OFF)
    else $error("failure flag set without forwarded frame");
  a_fail_sets: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (s_fwd_armed and s_lost) |=> st.sync_fail)
    else $error("failure flag not set on lost sync");
  a_fail_read_clear: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    rd_en && idx == IDX_FORWARDING_SYNC_STATUS && !i_sync_lost |=> !st.sync_fail && o_apb.prdata[BIT_SYNC_FAIL] == $past(st.sync_fail))
    else $error("failure flag not cleared by read");
  a_synced_off: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    st.sync_fwd == SYNC_FWD_OFF |-> !st.synced)
    else $error("synced bit high with forwarding off");
  a_summary_calc: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    st.summary == |(st.src_flag & st.irq_control[4:0]))
    else $error("summary bit wrong");
  a_host_irq: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_host_irq == (st.irq_control[BIT_GLOBAL_EN] && st.summary))
    else $error("host interrupt mismatch");
  a_tx_sticky: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    st.src_flag[BIT_TX0] && !i_clr.tx0_cause_read |=> st.src_flag[BIT_TX0])
    else $error("transmitter flag lost without read");
  a_port_clear: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_clr.port_a_read[0] && !i_port_irq[0] |=> !st.src_flag[0])
    else $error("port flag not cleared by read");
  a_edge_select: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $changed(st.stamp_config[BIT_EDGE]) |=> o_stamp.edge_falling == $past(st.stamp_config[BIT_EDGE]))
    else $error("edge select not applied");
  a_res_count: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_stamp.resolution == 2'h3 |-> o_stamp_count_ns == 8'h28)
    else $error("resolution count wrong");

  // bus, flag and decode checks; cheap guards against later edits
  sequence s_setup;
    i_apb.psel && !i_apb.penable && st.phase == HIS_IDLE;
  endsequence

  sequence s_access;
    i_apb.psel && i_apb.penable && !st.pready;
  endsequence

  sequence s_tx_clear;
    i_clr.tx0_cause_read && !i_tx0_irq;
  endsequence

  a_apb_wait: assert property (
    s_setup ##1 s_access |=> o_apb.pready)
    else $error("ready not given after one wait state");

  a_pready_pulse: assert property (
    o_apb.pready |=> !o_apb.pready)
    else $error("ready longer than one cycle");

  a_idle_no_ready: assert property (
    st.phase == HIS_IDLE |=> !o_apb.pready)
    else $error("ready without access phase");

  a_err_has_ready: assert property (
    o_apb.pslverr |-> o_apb.pready)
    else $error("error without ready");

  a_err_zero_data: assert property (
    o_apb.pslverr |-> o_apb.prdata == 32'h0000_0000)
    else $error("error read data not zero");

  a_ctl_reserved: assert property (
    st.irq_control[6:5] == 2'h0)
    else $error("reserved control bits set");

  a_host_irq_off: assert property (
    !st.irq_control[BIT_GLOBAL_EN] |-> !o_host_irq)
    else $error("host interrupt with global enable off");

  a_summary_no_en: assert property (
    st.irq_control[4:0] == 5'h00 |-> !st.summary)
    else $error("summary set with no source enabled");

  a_tx_sets: assert property (
    i_tx0_irq |=> st.src_flag[BIT_TX0])
    else $error("transmitter flag not set");

  a_port0_sets: assert property (
    i_port_irq[0] |=> st.src_flag[0])
    else $error("port 0 flag not set");

  a_port1_sets: assert property (
    i_port_irq[1] |=> st.src_flag[1])
    else $error("port 1 flag not set");

  a_port2_sets: assert property (
    i_port_irq[2] |=> st.src_flag[2])
    else $error("port 2 flag not set");

  a_port3_sets: assert property (
    i_port_irq[3] |=> st.src_flag[3])
    else $error("port 3 flag not set");

  a_tx_clear: assert property (
    s_tx_clear |=> !st.src_flag[BIT_TX0])
    else $error("transmitter flag not cleared");

  a_port1_clear_b: assert property (
    i_clr.port_b_read[1] && !i_port_irq[1] |=> !st.src_flag[1])
    else $error("port 1 flag not cleared");

  a_port2_clear_csi: assert property (
    i_clr.port_csi_read[2] && !i_port_irq[2] |=> !st.src_flag[2])
    else $error("port 2 flag not cleared");

  a_port3_clear_a: assert property (
    i_clr.port_a_read[3] && !i_port_irq[3] |=> !st.src_flag[3])
    else $error("port 3 flag not cleared");

  a_port_sticky: assert property (
    st.src_flag[0] && !i_clr.port_a_read[0] && !i_clr.port_b_read[0]
    && !i_clr.port_csi_read[0] |=> st.src_flag[0])
    else $error("port 0 flag lost without read");

  a_synced_follow: assert property (
    st.sync_fwd != SYNC_FWD_OFF |-> st.synced == $past(i_engine_synced))
    else $error("synced bit does not follow engine");

  a_fail_hold: assert property (
    st.sync_fail && !(rd_en && idx == IDX_FORWARDING_SYNC_STATUS) |=> st.sync_fail)
    else $error("failure flag lost without read");

  a_fail_off: assert property (
    st.sync_fwd == SYNC_FWD_OFF && !st.sync_fail |=> !st.sync_fail)
    else $error("failure flag set with forwarding off");

  a_frame_off: assert property (
    st.sync_fwd == SYNC_FWD_OFF |-> !st.frame_done)
    else $error("frame seen kept with forwarding off");

  a_frame_arm: assert property (
    !wr_en && st.sync_fwd != SYNC_FWD_OFF && i_frame_forwarded |=> st.frame_done)
    else $error("forwarded frame not noted");

  a_fail_event: assert property (
    $rose(st.sync_fail) |-> st.evt_sts[EVT_FAIL])
    else $error("failure event not recorded");

  a_res_code0: assert property (
    o_stamp.resolution == 2'h0 |-> o_stamp_count_ns == 8'h01)
    else $error("resolution count wrong for code 0");

  a_res_code1: assert property (
    o_stamp.resolution == 2'h1 |-> o_stamp_count_ns == 8'h03)
    else $error("resolution count wrong for code 1");

  a_res_code2: assert property (
    o_stamp.resolution == 2'h2 |-> o_stamp_count_ns == 8'h06)
    else $error("resolution count wrong for code 2");

  a_free_run: assert property (
    o_stamp.free_run == st.stamp_config[BIT_FREE])
    else $error("free run select not applied");

  a_trigger: assert property (
    o_stamp.frame_start == st.stamp_config[BIT_TRIG])
    else $error("trigger select not applied");

  a_early: assert property (
    o_stamp.early_ready == st.stamp_config[BIT_EARLY])
    else $error("early ready not applied");

  a_res_field: assert property (
    o_stamp.resolution == st.stamp_config[LSB_RES +: 2])
    else $error("resolution field not applied");

  a_edge_level: assert property (
    o_stamp.edge_falling == st.stamp_config[BIT_EDGE])
    else $error("edge select level wrong");

  a_sel_out: assert property (
    o_sync_forwarding_select == st.sync_fwd)
    else $error("forwarding select output wrong");

  a_write_ctl: assert property (
    s_setup ##1 (s_access && i_apb.pwrite && idx == IDX_IRQ_CTL)
    |=> st.irq_control == ($past(i_apb.pwdata[7:0]) & 8'h9f))
    else $error("control write not taken");

  a_write_cfg: assert property (
    s_setup ##1 (s_access && i_apb.pwrite && idx == IDX_STAMP_CFG)
    |=> st.stamp_config == ($past(i_apb.pwdata[7:0]) & 8'h7b))
    else $error("stamp config write not taken");
endmodule

// ---- his_host_model.sv ----
// host model: apb master of the register bus
`timescale 1ns/10ps
module his_host_model (
  input wire logic i_ref_clk,
  input wire his_pkg::his_apb_rsp_t i_apb,
  output his_pkg::his_apb_req_t o_apb
);
  import his_pkg::*;
  initial o_apb = '0;
  // leading edge wait keeps two transfers from assigning the bus in one step
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rd,
                      output logic err);
    rd = 'x;
    err = 1'bx;
    @(posedge i_ref_clk);
    o_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: ADDR_W'({idx, 2'b00}), pwdata: {24'h0, wd}};
    @(posedge i_ref_clk);
    o_apb.penable <= 1'b1;
    // looked at mid-cycle: the edge that launches pready would race a read
    for (int n = 0; n < 16; n++) begin
      @(negedge i_ref_clk);
      if (i_apb.pready === 1'b1) begin
        rd = i_apb.prdata;
        err = i_apb.pslverr;
        break;
      end
    end
    @(posedge i_ref_clk);
    o_apb <= '0;
  endtask
endmodule

// ---- his_top_tb.sv ----
// testbench for the hub interrupt, sync status and stamp config block
`timescale 1ns/10ps
module his_top_tb;
  import his_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  his_apb_req_t apb_req;
  his_apb_rsp_t apb_rsp;
  logic i_frame_forwarded = 1'b0;
  logic i_sync_lost = 1'b0;
  logic i_engine_synced = 1'b0;
  logic i_tx0_irq = 1'b0;
  logic [3:0] i_port_irq = 4'h0;
  his_clr_t i_clr = '0;
  logic o_host_irq;
  logic o_evt_irq;
  logic [1:0] o_sync_forwarding_select;
  his_stamp_t o_stamp;
  logic [7:0] o_stamp_count_ns;
  logic [31:0] rd;
  logic err;
  int num_errors = 0;
  int check_count = 0;

  always #12.5 i_ref_clk = ~i_ref_clk;

  his_top i_his_top (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_apb(apb_req), .o_apb(apb_rsp),
    .i_frame_forwarded(i_frame_forwarded), .i_sync_lost(i_sync_lost), .i_engine_synced(i_engine_synced),
    .i_tx0_irq(i_tx0_irq), .i_port_irq(i_port_irq), .i_clr(i_clr), .o_host_irq(o_host_irq),
    .o_evt_irq(o_evt_irq), .o_sync_forwarding_select(o_sync_forwarding_select), .o_stamp(o_stamp),
    .o_stamp_count_ns(o_stamp_count_ns));
  his_host_model i_his_host_model (.i_ref_clk(i_ref_clk), .i_apb(apb_rsp), .o_apb(apb_req));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    i_his_host_model.xfer(1'b1, idx, d, rd, err);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    i_his_host_model.xfer(1'b0, idx, 8'h00, rd, err);
    chk(rd, {24'h0, exp});
  endtask

  task automatic t_reset;
    chk({24'h0, o_stamp_count_ns}, 32'h1);
    rdc(IDX_IRQ_CTL, RST_IRQ_CTL);
    rdc(IDX_IRQ_SUM, 8'h00);
    rdc(IDX_STAMP_CFG, RST_STAMP_CFG);
    rdc(IDX_FORWARDING_SYNC_STATUS, 8'h00);
    i_his_host_model.xfer(1'b0, 8'h7f, 8'h00, rd, err);
    chk({31'h0, err}, 32'h1);
    wr(IDX_IRQ_CTL, 8'hff);
    rdc(IDX_IRQ_CTL, 8'h9f);
    wr(IDX_STAMP_CFG, 8'hff);
    rdc(IDX_STAMP_CFG, 8'h7b);
    wr(IDX_IRQ_CTL, 8'h00);
    $display("reset test done");
  endtask

  task automatic t_sync;
    wr(IDX_EVT_MASK, 8'h07);
    wr(IDX_FWD_CTL, 8'h01);
    chk({30'h0, o_sync_forwarding_select}, 32'h1);
    @(posedge i_ref_clk);
    i_sync_lost <= 1'b1;
    @(posedge i_ref_clk);
    i_sync_lost <= 1'b0;
    rdc(IDX_FORWARDING_SYNC_STATUS, 8'h00);
    @(posedge i_ref_clk);
    i_frame_forwarded <= 1'b1;
    i_engine_synced <= 1'b1;
    @(posedge i_ref_clk);
    i_frame_forwarded <= 1'b0;
    rdc(IDX_FORWARDING_SYNC_STATUS, 8'h01);
    @(posedge i_ref_clk);
    i_sync_lost <= 1'b1;
    @(posedge i_ref_clk);
    i_sync_lost <= 1'b0;
    rdc(IDX_FORWARDING_SYNC_STATUS, 8'h05);
    rdc(IDX_FORWARDING_SYNC_STATUS, 8'h01);
    wr(IDX_FWD_CTL, 8'h00);
    rdc(IDX_FORWARDING_SYNC_STATUS, 8'h00);
    chk({31'h0, o_evt_irq}, 32'h1);
    wr(IDX_EVT_MASK, 8'h00);
    step(2);
    chk({31'h0, o_evt_irq}, 32'h0);
    wr(IDX_EVT_MASK, 8'h07);
    step(2);
    chk({31'h0, o_evt_irq}, 32'h1);
    rdc(IDX_EVT_STS, 8'h03);
    step(2);
    chk({31'h0, o_evt_irq}, 32'h0);
    i_engine_synced <= 1'b0;
    $display("sync test done");
  endtask

  task automatic t_irq;
    wr(IDX_IRQ_CTL, 8'h10);
    @(posedge i_ref_clk);
    i_port_irq <= 4'h1;
    @(posedge i_ref_clk);
    i_port_irq <= 4'h0;
    rdc(IDX_IRQ_SUM, 8'h01);
    @(posedge i_ref_clk);
    i_tx0_irq <= 1'b1;
    @(posedge i_ref_clk);
    i_tx0_irq <= 1'b0;
    rdc(IDX_IRQ_SUM, 8'h91);
    chk({31'h0, o_host_irq}, 32'h0);
    wr(IDX_IRQ_CTL, 8'h90);
    step(2);
    chk({31'h0, o_host_irq}, 32'h1);
    rdc(IDX_IRQ_SUM, 8'h91);
    @(posedge i_ref_clk);
    i_clr.port_a_read <= 4'h1;
    @(posedge i_ref_clk);
    i_clr <= '0;
    rdc(IDX_IRQ_SUM, 8'h90);
    @(posedge i_ref_clk);
    i_clr.tx0_cause_read <= 1'b1;
    @(posedge i_ref_clk);
    i_clr <= '0;
    step(2);
    chk({31'h0, o_host_irq}, 32'h0);
    rdc(IDX_IRQ_SUM, 8'h00);
    for (int p = 1; p < 4; p++) begin
      wr(IDX_IRQ_CTL, 8'h80 | (8'h1 << p));
      @(posedge i_ref_clk);
      i_port_irq <= 4'h1 << p;
      @(posedge i_ref_clk);
      i_port_irq <= 4'h0;
      step(2);
      chk({31'h0, o_host_irq}, 32'h1);
      @(posedge i_ref_clk);
      i_clr.port_b_read[p] <= (p == 1);
      i_clr.port_csi_read[p] <= (p == 2);
      i_clr.port_a_read[p] <= (p == 3);
      @(posedge i_ref_clk);
      i_clr <= '0;
      rdc(IDX_IRQ_SUM, 8'h00);
    end
    $display("interrupt test done");
  endtask

  task automatic t_stamp;
    logic [7:0] v;
    int unsigned ns [4] = '{40, 80, 160, 1000};
    for (int c = 0; c < 4; c++) begin
      v = {1'b0, c[0], c[1:0], c[1], 1'b0, c[1], c[0]};
      wr(IDX_STAMP_CFG, v);
      rdc(IDX_STAMP_CFG, v);
      chk({26'h0, o_stamp}, {26'h0, c[0], c[1:0], c[1], c[1], c[0]});
      chk({24'h0, o_stamp_count_ns}, {24'h0, 8'(ns[c] / 25)});
    end
    $display("stamp test done");
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    step(1);
    t_reset;
    t_sync;
    t_irq;
    t_stamp;
    final_report;
  end

  // whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    num_errors++;
    final_report;
  end
endmodule
